// ==== urs_regs.sv ====
// Register bank with defined reset state, flow characters and reset pin levels
`timescale 1ns/100ps
// Behaviour
// R1: Four read/write flow-control character registers
// R2: Divisor and holding registers left uninitialised
// R3: Control registers clear to zero on reset
// R4: Status reads no interrupt pending after reset
// R5: Line status resets to transmitter-empty only
// R6: Modem deltas clear; upper bits follow inputs
// R7: Infrared pulse width clears to zero
// R8: Scratch register resets to all ones
// R9: Enhanced features and flow characters clear
// R10: Transmit idles high, low in infrared
// R11: Modem and user outputs reset high
// R12: Transmit ready low, receive ready high
// R13: Strobe interrupt low; PC requests float
// R14: Special character match flags status
// R15: Host writes divisors before transmitting
module urs_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [urs_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    output logic tx_char_valid,
    output logic [7:0] tx_char,
    input wire logic tx_char_done,
    input wire logic tx_bit,
    input wire logic tx_ir_bit,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic ri_n,
    input wire logic cd_n,
    input wire logic pc_mode,
    output logic [15:0] divisor,
    output logic [7:0] ir_pulse_width,
    output logic tx_paused,
    output logic tx_out,
    output logic rts_n,
    output logic dtr_n,
    output logic user_out_one_n,
    output logic user_out_two_n,
    output logic tx_ready_n,
    output logic rx_ready_n,
    output logic irq_out,
    output logic irq_req_a,
    output logic irq_req_b,
    output logic irq_req_c,
    output logic irq_oe_n
);
    logic [7:0] irq_enable_reg, fifo_control_reg, line_control_reg, modem_control_reg, extended_feature_reg, ir_pulse_width_reg, scratch, enhanced_feature_reg;
    logic [7:0] resume_char_one, resume_char_two, pause_char_one, pause_char_two;
    logic [7:0] next_ier, next_fcr, next_lcr, next_mcr, next_xfr, next_ir_pulse_width_reg;
    logic [7:0] next_scratch, next_efr;
    logic [7:0] next_res1, next_res2, next_pau1, next_pau2;
    logic [urs_pkg::EV_W-1:0] evt_status, evt_mask, next_evt_status, next_evt_mask;
    logic rx_full, thr_full, overrun, next_rx_full, next_thr_full, next_overrun;
    logic [urs_pkg::MODEM_W-1:0] msr_delta, msr_prev, next_msr_delta;
    logic msr_primed;
    logic next_tx_paused;
    logic [7:0] rx_holding, tx_holding, divisor_low, divisor_high;
    logic [7:0] next_rdata;
    logic next_tx_out, next_rts_n, next_dtr_n, next_op1_n, next_op2_n;
    logic next_irq_out, next_irq_oe_n;
    logic [urs_pkg::MODEM_W-1:0] modem_sync, modem_level;
    logic pc_sync;
    logic [urs_pkg::CHAR_N-1:0] match;
    logic [7:0] isr_val, lsr_val, msr_val;
    logic dlab, enh_open, wr_hold, rd_hold, spec_hit, pause_hit, resume_hit, irq_level;
    urs_pkg::urs_rxfc_t rx_fc_mode;

    urs_sync #(.WIDTH(urs_pkg::MODEM_W), .RST_VAL(4'hf)) u_modem_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin({cd_n, ri_n, dsr_n, cts_n}),
        .sync(modem_sync)
    );

    urs_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_mode_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin(pc_mode),
        .sync(pc_sync)
    );

    urs_char_match u_match (
        .rx_char(rx_char),
        .resume_char_one(resume_char_one),
        .resume_char_two(resume_char_two),
        .pause_char_one(pause_char_one),
        .pause_char_two(pause_char_two),
        .match(match)
    );

    assign dlab = line_control_reg[urs_pkg::LCR_DLAB];
    assign enh_open = enhanced_feature_reg[urs_pkg::EFR_ENH];
    assign wr_hold = wr && addr == urs_pkg::A_HOLD && !dlab;
    assign rd_hold = rd && addr == urs_pkg::A_HOLD && !dlab;
    assign divisor = {divisor_high, divisor_low};
    assign ir_pulse_width = ir_pulse_width_reg;
    assign tx_char = tx_holding;
    assign tx_char_valid = thr_full && !tx_paused;
    assign rx_fc_mode = urs_pkg::urs_rxfc_t'(enhanced_feature_reg[1:0]);
    // Special character compare against the second pause character
    assign spec_hit = rx_char_valid && enhanced_feature_reg[urs_pkg::EFR_SPEC] && match[urs_pkg::CH_PAU2]; // [R14]
    assign irq_level = |(evt_status & evt_mask);

    // Modem levels: complement of pins, or control bits in loopback
    always_comb begin
        if (modem_control_reg[urs_pkg::MCR_LOOP]) begin
            modem_level = {modem_control_reg[urs_pkg::MCR_OP2], modem_control_reg[urs_pkg::MCR_OP1],
                           modem_control_reg[urs_pkg::MCR_DTR], modem_control_reg[urs_pkg::MCR_RTS]};
        end else begin
            modem_level = ~modem_sync;
        end
    end

    // Receive flow compare set selected by the enhanced feature bits
    always_comb begin
        pause_hit = 1'b0;
        resume_hit = 1'b0;
        case (rx_fc_mode)
            urs_pkg::URS_FC_SET1: begin
                pause_hit = match[urs_pkg::CH_PAU1];
                resume_hit = match[urs_pkg::CH_RES1];
            end
            urs_pkg::URS_FC_SET2: begin
                pause_hit = match[urs_pkg::CH_PAU2];
                resume_hit = match[urs_pkg::CH_RES2];
            end
            urs_pkg::URS_FC_BOTH: begin
                pause_hit = match[urs_pkg::CH_PAU1] || match[urs_pkg::CH_PAU2];
                resume_hit = match[urs_pkg::CH_RES1] || match[urs_pkg::CH_RES2];
            end
            default: begin
                pause_hit = 1'b0;
                resume_hit = 1'b0;
            end
        endcase
        pause_hit = pause_hit && rx_char_valid;
        resume_hit = resume_hit && rx_char_valid;
    end

    // Interrupt identification, no interrupt pending reads as idle code
    always_comb begin
        if (evt_status[urs_pkg::EV_SPEC] && irq_enable_reg[urs_pkg::IER_SPEC]) begin
            isr_val = urs_pkg::ISR_SPEC; // [R14]
        end else if (rx_full && irq_enable_reg[urs_pkg::IER_RX]) begin
            isr_val = urs_pkg::ISR_RX;
        end else if (!thr_full && evt_status[urs_pkg::EV_TXE] && irq_enable_reg[urs_pkg::IER_TX]) begin
            isr_val = urs_pkg::ISR_TX;
        end else if ((|msr_delta) && irq_enable_reg[urs_pkg::IER_MODEM]) begin
            isr_val = urs_pkg::ISR_MODEM;
        end else begin
            isr_val = urs_pkg::ISR_NONE; // [R4]
        end
        isr_val[7:6] = {2{fifo_control_reg[urs_pkg::FCR_EN]}};
    end

    // Line and modem status views
    always_comb begin
        lsr_val = urs_pkg::RST_ZERO;
        lsr_val[urs_pkg::LSR_DR] = rx_full;
        lsr_val[urs_pkg::LSR_OVR] = overrun;
        lsr_val[urs_pkg::LSR_THRE] = !thr_full; // [R5]
        lsr_val[urs_pkg::LSR_TEMT] = !thr_full; // [R5]
        msr_val = {modem_level, msr_delta}; // [R6]
    end

    // Next values of the control registers and status
    always_comb begin
        next_ier = irq_enable_reg;
        next_fcr = fifo_control_reg;
        next_lcr = line_control_reg;
        next_mcr = modem_control_reg;
        next_xfr = extended_feature_reg;
        next_ir_pulse_width_reg = ir_pulse_width_reg;
        next_scratch = scratch;
        next_efr = enhanced_feature_reg;
        next_res1 = resume_char_one;
        next_res2 = resume_char_two;
        next_pau1 = pause_char_one;
        next_pau2 = pause_char_two;
        next_evt_mask = evt_mask;
        next_evt_status = evt_status;
        next_rx_full = rx_full;
        next_thr_full = thr_full;
        next_overrun = overrun;
        next_msr_delta = msr_delta;
        next_tx_paused = tx_paused;
        if (wr) begin
            case (addr)
                urs_pkg::A_IER: begin
                    if (!dlab) begin
                        next_ier = enh_open ? wdata : ((irq_enable_reg & urs_pkg::ENH_IER)
                                   | (wdata & ~urs_pkg::ENH_IER));
                    end
                end
                urs_pkg::A_ISR: begin
                    next_fcr = enh_open ? wdata : ((fifo_control_reg & urs_pkg::ENH_FCR)
                               | (wdata & ~urs_pkg::ENH_FCR));
                end
                urs_pkg::A_LCR: next_lcr = wdata;
                urs_pkg::A_MCR: begin
                    next_mcr = enh_open ? wdata : ((modem_control_reg & urs_pkg::ENH_MCR)
                               | (wdata & ~urs_pkg::ENH_MCR));
                end
                urs_pkg::A_SPR: next_scratch = wdata;
                urs_pkg::A_EFR: next_efr = wdata;
                urs_pkg::A_XFR: next_xfr = enh_open ? wdata : extended_feature_reg;
                urs_pkg::A_IR_PULSE_WIDTH_REG: next_ir_pulse_width_reg = enh_open ? wdata : ir_pulse_width_reg;
                urs_pkg::A_RES1: next_res1 = wdata; // [R1]
                urs_pkg::A_RES2: next_res2 = wdata; // [R1]
                urs_pkg::A_PAU1: next_pau1 = wdata; // [R1]
                urs_pkg::A_PAU2: next_pau2 = wdata; // [R1]
                urs_pkg::A_EVMSK: next_evt_mask = wdata[urs_pkg::EV_W-1:0];
                default: next_ier = irq_enable_reg;
            endcase
        end
        // Read side effects; sets below win over these clears
        if (rd_hold) begin
            next_rx_full = 1'b0;
        end
        if (rd && addr == urs_pkg::A_LSR) begin
            next_overrun = 1'b0;
        end
        if (rd && addr == urs_pkg::A_MSR) begin
            next_msr_delta = '0;
        end
        if (rd && addr == urs_pkg::A_EVST) begin
            next_evt_status = '0;
        end
        if (tx_char_done) begin
            next_thr_full = 1'b0;
            next_evt_status[urs_pkg::EV_TXE] = 1'b1;
        end
        if (wr_hold) begin
            next_thr_full = 1'b1;
        end
        if (rx_char_valid) begin
            next_overrun = overrun || rx_full;
            next_rx_full = 1'b1;
            next_evt_status[urs_pkg::EV_RX] = 1'b1;
        end
        if (msr_primed) begin
            next_msr_delta = next_msr_delta | (modem_level ^ msr_prev); // [R6]
        end
        if (|next_msr_delta && !(|msr_delta)) begin
            next_evt_status[urs_pkg::EV_MODEM] = 1'b1;
        end
        if (spec_hit) begin
            next_evt_status[urs_pkg::EV_SPEC] = 1'b1; // [R14]
        end
        if (pause_hit) begin
            next_tx_paused = 1'b1;
            next_evt_status[urs_pkg::EV_PAUSE] = 1'b1;
        end else if (resume_hit || rx_fc_mode == urs_pkg::URS_FC_OFF) begin
            next_tx_paused = 1'b0;
        end
    end

    // Control registers: all take their documented reset values
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_enable_reg <= urs_pkg::RST_ZERO; // [R3]
            fifo_control_reg <= urs_pkg::RST_ZERO; // [R3]
            line_control_reg <= urs_pkg::RST_ZERO; // [R3]
            modem_control_reg <= urs_pkg::RST_ZERO; // [R3]
            extended_feature_reg <= urs_pkg::RST_ZERO; // [R3]
            ir_pulse_width_reg <= urs_pkg::RST_ZERO; // [R7]
            scratch <= urs_pkg::RST_SPR; // [R8]
            enhanced_feature_reg <= urs_pkg::RST_ZERO; // [R9]
            resume_char_one <= urs_pkg::RST_ZERO; // [R9]
            resume_char_two <= urs_pkg::RST_ZERO; // [R9]
            pause_char_one <= urs_pkg::RST_ZERO; // [R9]
            pause_char_two <= urs_pkg::RST_ZERO; // [R9]
            evt_mask <= '0;
            evt_status <= '0;
            rx_full <= 1'b0;
            thr_full <= 1'b0;
            overrun <= 1'b0;
            msr_delta <= '0; // [R6]
            tx_paused <= 1'b0;
        end else begin
            irq_enable_reg <= next_ier;
            fifo_control_reg <= next_fcr;
            line_control_reg <= next_lcr;
            modem_control_reg <= next_mcr;
            extended_feature_reg <= next_xfr;
            ir_pulse_width_reg <= next_ir_pulse_width_reg;
            scratch <= next_scratch;
            enhanced_feature_reg <= next_efr;
            resume_char_one <= next_res1;
            resume_char_two <= next_res2;
            pause_char_one <= next_pau1;
            pause_char_two <= next_pau2;
            evt_mask <= next_evt_mask;
            evt_status <= next_evt_status;
            rx_full <= next_rx_full;
            thr_full <= next_thr_full;
            overrun <= next_overrun;
            msr_delta <= next_msr_delta;
            tx_paused <= next_tx_paused;
        end
    end

    // Previous modem levels; deltas only once a reference exists
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            msr_prev <= '0;
            msr_primed <= 1'b0;
        end else begin
            msr_prev <= modem_level;
            msr_primed <= 1'b1;
        end
    end

    // Data registers without reset: contents undefined until written
    always_ff @(posedge clk) begin
        if (wr && addr == urs_pkg::A_HOLD && dlab) begin
            divisor_low <= wdata; // [R2]
        end
        if (wr && addr == urs_pkg::A_IER && dlab) begin
            divisor_high <= wdata; // [R2]
        end
        if (wr_hold) begin
            tx_holding <= wdata; // [R2]
        end
        if (rx_char_valid) begin
            rx_holding <= rx_char; // [R2]
        end
    end

    // Read data mux, answered the cycle after the strobe
    always_comb begin
        next_rdata = urs_pkg::RST_ZERO;
        if (rd) begin
            case (addr)
                urs_pkg::A_HOLD: next_rdata = dlab ? divisor_low : rx_holding;
                urs_pkg::A_IER: next_rdata = dlab ? divisor_high : irq_enable_reg;
                urs_pkg::A_ISR: next_rdata = isr_val;
                urs_pkg::A_LCR: next_rdata = line_control_reg;
                urs_pkg::A_MCR: next_rdata = modem_control_reg;
                urs_pkg::A_LSR: next_rdata = lsr_val;
                urs_pkg::A_MSR: next_rdata = msr_val;
                urs_pkg::A_SPR: next_rdata = scratch;
                urs_pkg::A_EFR: next_rdata = enhanced_feature_reg;
                urs_pkg::A_XFR: next_rdata = extended_feature_reg;
                urs_pkg::A_RES1: next_rdata = resume_char_one; // [R1]
                urs_pkg::A_RES2: next_rdata = resume_char_two; // [R1]
                urs_pkg::A_PAU1: next_rdata = pause_char_one; // [R1]
                urs_pkg::A_PAU2: next_rdata = pause_char_two; // [R1]
                urs_pkg::A_EVST: next_rdata = {3'h0, evt_status};
                urs_pkg::A_EVMSK: next_rdata = {3'h0, evt_mask};
                default: next_rdata = urs_pkg::RST_ZERO;
            endcase
        end
    end

    // Pin levels derived from the registers
    always_comb begin
        if (modem_control_reg[urs_pkg::MCR_LOOP]) begin
            next_tx_out = !modem_control_reg[urs_pkg::MCR_IR];
        end else begin
            next_tx_out = modem_control_reg[urs_pkg::MCR_IR] ? tx_ir_bit : tx_bit; // [R10]
        end
        next_rts_n = !modem_control_reg[urs_pkg::MCR_RTS] || modem_control_reg[urs_pkg::MCR_LOOP]; // [R11]
        next_dtr_n = !modem_control_reg[urs_pkg::MCR_DTR] || modem_control_reg[urs_pkg::MCR_LOOP]; // [R11]
        next_op1_n = !modem_control_reg[urs_pkg::MCR_OP1] || modem_control_reg[urs_pkg::MCR_LOOP]; // [R11]
        next_op2_n = !modem_control_reg[urs_pkg::MCR_OP2] || modem_control_reg[urs_pkg::MCR_LOOP]; // [R11]
        next_irq_out = irq_level && !pc_sync; // [R13]
        next_irq_oe_n = !(pc_sync && modem_control_reg[urs_pkg::MCR_OP2]); // [R13]
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= urs_pkg::RST_ZERO;
            tx_out <= 1'b1; // [R10]
            rts_n <= 1'b1; // [R11]
            dtr_n <= 1'b1; // [R11]
            user_out_one_n <= 1'b1; // [R11]
            user_out_two_n <= 1'b1; // [R11]
            tx_ready_n <= 1'b0; // [R12]
            rx_ready_n <= 1'b1; // [R12]
            irq_out <= 1'b0; // [R13]
            irq_oe_n <= 1'b1; // [R13]
            irq_req_a <= 1'b0;
        end else begin
            rdata <= next_rdata;
            tx_out <= next_tx_out;
            rts_n <= next_rts_n;
            dtr_n <= next_dtr_n;
            user_out_one_n <= next_op1_n;
            user_out_two_n <= next_op2_n;
            tx_ready_n <= next_thr_full; // [R12]
            rx_ready_n <= !next_rx_full; // [R12]
            irq_out <= next_irq_out;
            irq_oe_n <= next_irq_oe_n;
            irq_req_a <= irq_level;
        end
    end
    assign irq_req_b = irq_req_a;
    assign irq_req_c = irq_req_a;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_flow_write: assert property (wr && addr == urs_pkg::A_PAU2 |=> // [R1]
        pause_char_two == $past(wdata)) else $error("pause char two not written");
    chk_ctrl_reset: assert property ($rose(rst_b) |-> irq_enable_reg == 8'h00 && fifo_control_reg == 8'h00 // [R3]
        && line_control_reg == 8'h00 && modem_control_reg == 8'h00 && extended_feature_reg == 8'h00) else $error("control not cleared");
    chk_isr_idle: assert property ($rose(rst_b) |-> isr_val == 8'h01) // [R4]
        else $error("isr not idle after reset");
    chk_lsr_reset: assert property ($rose(rst_b) |-> lsr_val == 8'h60) // [R5]
        else $error("lsr reset value wrong");
    chk_msr_delta: assert property ($rose(rst_b) |-> msr_delta == 4'h0 // [R6]
        && msr_val[7:4] == ~modem_sync) else $error("msr reset wrong");
    chk_scratch_reset: assert property ($rose(rst_b) |-> scratch == 8'hff // [R8]
        && ir_pulse_width_reg == 8'h00) else $error("scratch or pulse width reset wrong");
    chk_flow_reset: assert property ($rose(rst_b) |-> enhanced_feature_reg == 8'h00 // [R9]
        && pause_char_one == 8'h00 && pause_char_two == 8'h00 && resume_char_one == 8'h00
        && resume_char_two == 8'h00 && !tx_paused) else $error("flow reset wrong");
    chk_tx_idle: assert property (modem_control_reg[urs_pkg::MCR_LOOP] |=> // [R10]
        tx_out == !$past(modem_control_reg[urs_pkg::MCR_IR])) else $error("tx idle level wrong");
    chk_pins_reset: assert property ($rose(rst_b) |-> rts_n && dtr_n && user_out_one_n // [R11]
        && user_out_two_n && !tx_ready_n && rx_ready_n) else $error("pin reset wrong");
    chk_irq_reset: assert property ($rose(rst_b) |-> !irq_out && irq_oe_n) // [R13]
        else $error("interrupt pins reset wrong");
    chk_special_char: assert property (spec_hit |=> evt_status[urs_pkg::EV_SPEC] // [R14]
        ##1 (evt_status[urs_pkg::EV_SPEC] || $past(rd && addr == urs_pkg::A_EVST)))
        else $error("special char not flagged");
endmodule : urs_regs

// ==== urs_pkg.sv ====
// Shared constants and types of the reset-state register bank
package urs_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int MODEM_W = 4;
    localparam int EV_W = 5;
    localparam int CHAR_N = 4;
    // Register addresses on the plain port
    localparam logic [4:0] A_HOLD = 5'h00;
    localparam logic [4:0] A_IER = 5'h01;
    localparam logic [4:0] A_ISR = 5'h02;
    localparam logic [4:0] A_LCR = 5'h03;
    localparam logic [4:0] A_MCR = 5'h04;
    localparam logic [4:0] A_LSR = 5'h05;
    localparam logic [4:0] A_MSR = 5'h06;
    localparam logic [4:0] A_SPR = 5'h07;
    localparam logic [4:0] A_EFR = 5'h08;
    localparam logic [4:0] A_XFR = 5'h09;
    localparam logic [4:0] A_IR_PULSE_WIDTH_REG = 5'h0a;
    localparam logic [4:0] A_RES1 = 5'h0b;
    localparam logic [4:0] A_RES2 = 5'h0c;
    localparam logic [4:0] A_PAU1 = 5'h0d;
    localparam logic [4:0] A_PAU2 = 5'h0e;
    localparam logic [4:0] A_EVST = 5'h0f;
    localparam logic [4:0] A_EVMSK = 5'h10;
    // Reset values and interrupt identification codes
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SPR = 8'hff;
    localparam logic [7:0] RST_LSR = 8'h60;
    localparam logic [7:0] ISR_NONE = 8'h01;
    localparam logic [7:0] ISR_SPEC = 8'h10;
    localparam logic [7:0] ISR_RX = 8'h04;
    localparam logic [7:0] ISR_TX = 8'h02;
    localparam logic [7:0] ISR_MODEM = 8'h00;
    // Field positions
    localparam int LCR_DLAB = 7;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OP1 = 2;
    localparam int MCR_OP2 = 3;
    localparam int MCR_LOOP = 4;
    localparam int MCR_IR = 6;
    localparam int EFR_ENH = 4;
    localparam int EFR_SPEC = 5;
    localparam int FCR_EN = 0;
    localparam int LSR_DR = 0;
    localparam int LSR_OVR = 1;
    localparam int LSR_THRE = 5;
    localparam int LSR_TEMT = 6;
    localparam int IER_RX = 0;
    localparam int IER_TX = 1;
    localparam int IER_MODEM = 3;
    localparam int IER_SPEC = 5;
    // Bits writable only while enhanced mode is open
    localparam logic [7:0] ENH_IER = 8'hf0;
    localparam logic [7:0] ENH_FCR = 8'h30;
    localparam logic [7:0] ENH_MCR = 8'he0;
    // Event bits of the sticky status register
    localparam int EV_RX = 0;
    localparam int EV_TXE = 1;
    localparam int EV_MODEM = 2;
    localparam int EV_SPEC = 3;
    localparam int EV_PAUSE = 4;
    // Flow character indices
    localparam int CH_RES1 = 0;
    localparam int CH_RES2 = 1;
    localparam int CH_PAU1 = 2;
    localparam int CH_PAU2 = 3;
    typedef enum logic [1:0] {
        URS_FC_OFF = 2'b00,
        URS_FC_SET2 = 2'b01,
        URS_FC_SET1 = 2'b10,
        URS_FC_BOTH = 2'b11
    } urs_rxfc_t;
endpackage : urs_pkg

// ==== urs_sync.sv ====
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module urs_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] sync
);
    logic [WIDTH-1:0] meta;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    meta[i] <= RST_VAL[i];
                    sync[i] <= RST_VAL[i];
                end else begin
                    meta[i] <= pin[i];
                    sync[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule : urs_sync

// ==== urs_char_match.sv ====
// Compares a received character with the four flow characters
`timescale 1ns/100ps
module urs_char_match (
    input wire logic [7:0] rx_char,
    input wire logic [7:0] resume_char_one,
    input wire logic [7:0] resume_char_two,
    input wire logic [7:0] pause_char_one,
    input wire logic [7:0] pause_char_two,
    output logic [urs_pkg::CHAR_N-1:0] match
);
    logic [7:0] chars [urs_pkg::CHAR_N];
    assign chars[urs_pkg::CH_RES1] = resume_char_one;
    assign chars[urs_pkg::CH_RES2] = resume_char_two;
    assign chars[urs_pkg::CH_PAU1] = pause_char_one;
    assign chars[urs_pkg::CH_PAU2] = pause_char_two;
    genvar i;
    generate
        for (i = 0; i < urs_pkg::CHAR_N; i++) begin : g_cmp
            assign match[i] = (rx_char == chars[i]);
        end
    endgenerate
endmodule : urs_char_match

// ==== urs_tx_model.sv ====
// Transmitter model that takes characters from the register bank
`timescale 1ns/100ps
module urs_tx_model #(
    parameter int DELAY = 5
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tx_char_valid,
    output logic tx_char_done,
    output logic tx_bit,
    output logic tx_ir_bit
);
    int cnt;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            tx_char_done <= 1'b0;
        end else begin
            tx_char_done <= tx_char_valid && cnt == DELAY && !tx_char_done;
            cnt <= (tx_char_valid && cnt < DELAY) ? cnt + 1 : 0;
        end
    end
    assign tx_bit = 1'b1; // Normal idle level
    assign tx_ir_bit = 1'b0; // Encoder idle level
endmodule : urs_tx_model

// ==== uart_reset_state_and_flow_chars_tb_top.sv ====
// Self-checking testbench of the reset-state register bank
`timescale 1ns/100ps
module uart_reset_state_and_flow_chars_tb_top;
    logic clk, rst_b, wr, rd, rx_char_valid, tx_char_valid, tx_char_done, tx_bit, tx_ir_bit;
    logic tx_out, rts_n, dtr_n, user_out_one_n, user_out_two_n, tx_ready_n, rx_ready_n;
    logic irq_out, irq_oe_n, pc_mode;
    logic [4:0] addr;
    logic [7:0] wdata, rdata, rx_char, ipw;
    logic [3:0] pins;
    logic [15:0] div;
    logic [8:0] pinv;
    int err_total, tests_run, n;
    assign pinv = {tx_out, rts_n, dtr_n, user_out_one_n, user_out_two_n, tx_ready_n,
        rx_ready_n, irq_out, irq_oe_n};
    urs_regs DUT (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .rx_char_valid, .rx_char,
        .tx_char_valid, .tx_char(), .tx_char_done, .tx_bit, .tx_ir_bit, .cts_n(pins[0]),
        .dsr_n(pins[1]), .ri_n(pins[2]), .cd_n(pins[3]), .pc_mode, .divisor(div),
        .ir_pulse_width(ipw), .tx_paused(), .tx_out, .rts_n, .dtr_n, .user_out_one_n,
        .user_out_two_n, .tx_ready_n, .rx_ready_n, .irq_out, .irq_req_a(), .irq_req_b(),
        .irq_req_c(), .irq_oe_n);
    urs_tx_model PM (.clk, .rst_b, .tx_char_valid, .tx_char_done, .tx_bit, .tx_ir_bit);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk({1'b0, rdata}, {1'b0, exp});
    endtask : rreg
    task automatic do_reset;
        logic [7:0] e;
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        #1 chk(pinv, 9'h1f5);
        chk({1'b0, ipw}, 9'h000);
        for (int a = 1; a < 15; a++) begin
            e = (a == 2) ? 8'h01 : (a == 5) ? 8'h60 : (a == 7) ? 8'hff : 8'h00;
            if (a != 10) rreg(5'(a), e);
        end
    endtask : do_reset
    task automatic irq_scn;
        wreg(urs_pkg::A_EFR, 8'h30);
        wreg(urs_pkg::A_IER, 8'h20);
        wreg(urs_pkg::A_PAU2, 8'h13);
        @(posedge clk);
        rx_char <= 8'h13;
        rx_char_valid <= 1'b1;
        @(posedge clk);
        rx_char_valid <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({8'h00, irq_out}, 9'h000);
        chk({8'h00, rx_ready_n}, 9'h000);
        rreg(urs_pkg::A_ISR, 8'h10);
        wreg(urs_pkg::A_EVMSK, 8'h08);
        repeat (3) @(posedge clk);
        #1 chk({8'h00, irq_out}, 9'h001);
        rreg(urs_pkg::A_EVST, 8'h09);
        repeat (3) @(posedge clk);
        #1 chk({8'h00, irq_out}, 9'h000);
    endtask : irq_scn
    task automatic tx_ir_scn;
        wreg(urs_pkg::A_LCR, 8'h80);
        wreg(urs_pkg::A_HOLD, 8'h0c);
        wreg(urs_pkg::A_IER, 8'h01);
        rreg(urs_pkg::A_HOLD, 8'h0c);
        chk({1'b0, div[15:8]}, 9'h001);
        wreg(urs_pkg::A_LCR, 8'h00);
        wreg(urs_pkg::A_HOLD, 8'h55);
        repeat (2) @(posedge clk);
        #1;
        for (n = 0; n < 40 && tx_ready_n !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 40) begin
            err_total++;
            give_verdict;
        end
        rreg(urs_pkg::A_EVST, 8'h02);
        wreg(urs_pkg::A_IR_PULSE_WIDTH_REG, 8'h07);
        wreg(urs_pkg::A_MCR, 8'h40);
        repeat (3) @(posedge clk);
        #1 chk({8'h00, tx_out}, 9'h000);
        chk({1'b0, ipw}, 9'h007);
        wreg(urs_pkg::A_MCR, 8'h13);
        repeat (3) @(posedge clk);
        #1 chk({8'h00, tx_out}, 9'h001);
        chk({7'h00, rts_n, dtr_n}, 9'h003);
        rreg(urs_pkg::A_MSR, 8'h33);
    endtask : tx_ir_scn
    initial begin
        {rst_b, wr, rd, rx_char_valid, pc_mode, addr, wdata, rx_char} = '0;
        pins = 4'hf;
        err_total = 0;
        tests_run = 0;
        do_reset;
        for (int a = 11; a < 15; a++) wreg(5'(a), 8'(a * 17));
        for (int a = 11; a < 15; a++) rreg(5'(a), 8'(a * 17));
        wreg(5'h1f, 8'h3c);
        rreg(5'h1f, 8'h00);
        irq_scn;
        tx_ir_scn;
        @(posedge clk);
        pc_mode <= 1'b1;
        do_reset;
        give_verdict;
    end
endmodule : uart_reset_state_and_flow_chars_tb_top
